// >>> rtl/dtr_top.sv
// System-table locator registers: global and vector table pointers, local and task selectors.
// Assumes one execution core on ref_clk issues operations and a memory port on the same clock.
//
// What this block does
// RL1 - Global pointer holds a 32 or 64-bit base and 16-bit limit.
// RL2 - Global base addresses byte zero; limit is the byte offset of the table's last byte.
// RL3 - Dedicated load and save operations write and read the global pointer.
// RL4 - Reset sets global, vector and task bases to zero, limits to ffff.
// RL5 - Reset clears local selector and base, sets its limit to ffff.
// RL6 - Local locator holds selector, base, limit and attributes; base width by mode.
// RL7 - Local load and save move only the selector; hidden parts stay hidden.
// RL8 - Loading a local selector fetches its descriptor from the global table.
// RL9 - Task switch reloads the local locator without saving old contents.
// RL10 - Vector pointer holds a mode-dependent base and 16-bit byte limit.
// RL11 - Vector pointer has load and save operations; load replaces base and limit.
// RL12 - Task locator holds selector into global table, base, limit, attributes.
// RL13 - Task load and save move only the selector.
// RL14 - Loading a task selector fills base, limit, attributes from its descriptor.
// RL15 - Task switch reloads the task locator without saving old contents.
// RL16 - A save returns the last loaded value and has no side effect.
`timescale 1ns/10ps
`include "dtr_params.svh"
module dtr_top
  import dtr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic long_mode,
  input wire logic op_valid,
  input wire dtr_op_t op_kind,
  input wire logic [63:0] op_base,
  input wire logic [15:0] op_limit,
  input wire logic [15:0] op_sel,
  output logic op_ready,
  input wire logic switch_valid,
  input wire logic [15:0] switch_task_sel,
  input wire logic [15:0] switch_local_sel,
  output logic rd_valid,
  output logic [63:0] rd_base,
  output logic [15:0] rd_limit,
  output logic [15:0] rd_sel,
  output logic fault,
  output logic mem_req,
  output logic [63:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [127:0] mem_rdata,
  output logic [63:0] global_base,
  output logic [15:0] global_limit,
  output logic [63:0] vector_base,
  output logic [15:0] vector_limit,
  output logic [15:0] local_sel,
  output logic [63:0] local_base,
  output logic [31:0] local_limit,
  output logic [11:0] local_attr,
  output logic [15:0] task_sel,
  output logic [63:0] task_base,
  output logic [31:0] task_limit,
  output logic [11:0] task_attr
);

  // ********************************************************
  // Helpers
  // ********************************************************

  // Base in protected operation keeps only its low 32 bits.
  function automatic logic [63:0] mode_base(input logic lm, input logic [63:0] b);
    mode_base = lm ? b : {`DTR_UPPER_ZERO, b[31:0]};
  endfunction

  // Whole descriptor must lie inside the global table.
  function automatic logic sel_fits(input logic lm, input logic [15:0] sel,
                                    input logic [15:0] lim);
    logic [16:0] last;
    last = {1'b0, sel[`DTR_SEL_INDEX], `DTR_IDX_PAD};
    last = last + (lm ? `DTR_DESC_LAST_LONG : `DTR_DESC_LAST_LEGACY);
    sel_fits = (last <= {1'b0, lim});
  endfunction

  // Byte address of a selector's descriptor inside the global table.
  function automatic logic [63:0] desc_addr(input logic [63:0] gb, input logic [15:0] sel);
    desc_addr = gb + {48'h000000000000, sel[`DTR_SEL_INDEX], `DTR_IDX_PAD};
  endfunction

  // ********************************************************
  // State and sub-blocks
  // ********************************************************
  dtr_top_t s_q;
  dtr_top_t s_d;
  logic fetch_done;
  logic [127:0] fetch_data;
  logic local_fill;
  logic task_fill;
  logic [15:0] fill_sel_local;
  logic [15:0] fill_sel_task;
  logic [63:0] fill_base;
  logic [31:0] fill_limit;
  logic [11:0] fill_attr;
  logic [19:0] raw_limit;

  dtr_desc_fetch u_fetch (
    .ref_clk(ref_clk),
    .reset(reset),
    .start(s_q.start),
    .start_addr(s_q.start_addr),
    .mem_req(mem_req),
    .mem_addr(mem_addr),
    .mem_ack(mem_ack),
    .mem_rdata(mem_rdata),
    .done(fetch_done),
    .data(fetch_data)
  );

  dtr_seg_cache u_local (
    .ref_clk(ref_clk),
    .reset(reset),
    .fill(local_fill),
    .fill_sel(fill_sel_local),
    .fill_base(fill_base),
    .fill_limit(fill_limit),
    .fill_attr(fill_attr),
    .sel(local_sel),
    .base(local_base),
    .limit(local_limit),
    .attr(local_attr)
  );

  dtr_seg_cache u_task (
    .ref_clk(ref_clk),
    .reset(reset),
    .fill(task_fill),
    .fill_sel(fill_sel_task),
    .fill_base(fill_base),
    .fill_limit(fill_limit),
    .fill_attr(fill_attr),
    .sel(task_sel),
    .base(task_base),
    .limit(task_limit),
    .attr(task_attr)
  );

  // ********************************************************
  // Descriptor decode
  // ********************************************************
  always_comb begin
    raw_limit = {fetch_data[`DTR_D_LIM_HI], fetch_data[`DTR_D_LIM_LO]};
    fill_base = mode_base(long_mode, {fetch_data[`DTR_D_BASE_HI],
                fetch_data[`DTR_D_BASE_MID], fetch_data[`DTR_D_BASE_LO]}); // RL6
    fill_limit = fetch_data[`DTR_D_GRAN] ? {raw_limit, `DTR_PAGE_FILL}
                                         : {`DTR_LIM_PAD, raw_limit};
    fill_attr = {fetch_data[`DTR_D_ATTR_HI], fetch_data[`DTR_D_ATTR_LO]};
    fill_sel_local = s_q.pend_local;
    fill_sel_task = s_q.pend_task;
  end

  // ********************************************************
  // Sequencer
  // ********************************************************
  // A task switch outranks a core operation offered in the same cycle.
  always_comb begin
    s_d = s_q;
    s_d.rd_valid = 1'b0;
    s_d.fault = 1'b0;
    s_d.start = 1'b0;
    local_fill = 1'b0;
    task_fill = 1'b0;
    case (s_q.state)
      ST_IDLE: begin
        if (switch_valid) begin
          s_d.pend_task = switch_task_sel;
          s_d.pend_local = switch_local_sel;
          if (sel_fits(long_mode, switch_task_sel, s_q.gt_limit)) begin
            s_d.start = 1'b1;
            s_d.start_addr = desc_addr(s_q.gt_base, switch_task_sel); // RL15
            s_d.state = ST_SW_TASK;
          end else begin
            s_d.fault = 1'b1;
          end
        end else if (op_valid) begin
          case (op_kind)
            load_global_pointer_op: begin
              s_d.gt_base = mode_base(long_mode, op_base); // RL1 RL3
              s_d.gt_limit = op_limit; // RL2
            end
            save_global_pointer_op: begin
              s_d.rd_valid = 1'b1;
              s_d.rd_base = s_q.gt_base; // RL3 RL16
              s_d.rd_limit = s_q.gt_limit;
              s_d.rd_sel = `DTR_SEL_RST;
            end
            load_vector_pointer_op: begin
              s_d.vt_base = mode_base(long_mode, op_base); // RL10 RL11
              s_d.vt_limit = op_limit; // RL11
            end
            save_vector_pointer_op: begin
              s_d.rd_valid = 1'b1;
              s_d.rd_base = s_q.vt_base; // RL11 RL16
              s_d.rd_limit = s_q.vt_limit;
              s_d.rd_sel = `DTR_SEL_RST;
            end
            load_local_selector_op: begin
              s_d.pend_local = op_sel; // RL7
              if (sel_fits(long_mode, op_sel, s_q.gt_limit)) begin
                s_d.start = 1'b1;
                s_d.start_addr = desc_addr(s_q.gt_base, op_sel); // RL8
                s_d.state = ST_LOAD_LOCAL;
              end else begin
                s_d.fault = 1'b1;
              end
            end
            load_task_selector_op: begin
              s_d.pend_task = op_sel; // RL13
              if (sel_fits(long_mode, op_sel, s_q.gt_limit)) begin
                s_d.start = 1'b1;
                s_d.start_addr = desc_addr(s_q.gt_base, op_sel); // RL12 RL14
                s_d.state = ST_LOAD_TASK;
              end else begin
                s_d.fault = 1'b1;
              end
            end
            save_local_selector_op: begin
              s_d.rd_valid = 1'b1;
              s_d.rd_base = `DTR_BASE_RST;
              s_d.rd_limit = `DTR_SEL_RST;
              s_d.rd_sel = local_sel; // RL7 RL16
            end
            save_task_selector_op: begin
              s_d.rd_valid = 1'b1;
              s_d.rd_base = `DTR_BASE_RST;
              s_d.rd_limit = `DTR_SEL_RST;
              s_d.rd_sel = task_sel; // RL13 RL16
            end
            default: begin
              s_d.fault = 1'b1;
            end
          endcase
        end
      end
      ST_LOAD_LOCAL: begin
        if (fetch_done) begin
          local_fill = 1'b1; // RL8
          s_d.state = ST_IDLE;
        end
      end
      ST_LOAD_TASK: begin
        if (fetch_done) begin
          task_fill = 1'b1; // RL14
          s_d.state = ST_IDLE;
        end
      end
      ST_SW_TASK: begin
        if (fetch_done) begin
          task_fill = 1'b1; // RL15
          if (sel_fits(long_mode, s_q.pend_local, s_q.gt_limit)) begin
            s_d.start = 1'b1;
            s_d.start_addr = desc_addr(s_q.gt_base, s_q.pend_local);
            s_d.state = ST_SW_LOCAL;
          end else begin
            s_d.fault = 1'b1;
            s_d.state = ST_IDLE;
          end
        end
      end
      ST_SW_LOCAL: begin
        if (fetch_done) begin
          local_fill = 1'b1; // RL9
          s_d.state = ST_IDLE;
        end
      end
      default: begin
        s_d.state = ST_IDLE;
      end
    endcase
    s_d.ready = (s_d.state == ST_IDLE) && !s_d.start;
  end

  // ********************************************************
  // Registers
  // ********************************************************
  // Reset values are constants only; no mode input is sampled under reset.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
      s_q.state <= ST_IDLE;
      s_q.gt_base <= `DTR_BASE_RST; // RL4
      s_q.gt_limit <= `DTR_TBL_LIMIT_RST; // RL4
      s_q.vt_base <= `DTR_BASE_RST; // RL4
      s_q.vt_limit <= `DTR_TBL_LIMIT_RST; // RL4
      s_q.pend_task <= `DTR_SEL_RST;
      s_q.pend_local <= `DTR_SEL_RST; // RL5
      s_q.ready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign op_ready = s_q.ready;
  assign rd_valid = s_q.rd_valid;
  assign rd_base = s_q.rd_base;
  assign rd_limit = s_q.rd_limit;
  assign rd_sel = s_q.rd_sel;
  assign fault = s_q.fault;
  assign global_base = s_q.gt_base;
  assign global_limit = s_q.gt_limit;
  assign vector_base = s_q.vt_base;
  assign vector_limit = s_q.vt_limit;

endmodule

// >>> rtl/dtr_params.svh
// Constants of the system-table locator block: reset values, descriptor field positions.
// Assumes it is included by bare name from files under rtl/.
`ifndef DTR_PARAMS_SVH
`define DTR_PARAMS_SVH

// ********************************************************
// Reset values
// ********************************************************
`define DTR_BASE_RST 64'h0000000000000000
`define DTR_HID_LIMIT_RST 32'h0000ffff
`define DTR_TBL_LIMIT_RST 16'hffff
`define DTR_SEL_RST 16'h0000
`define DTR_ATTR_RST 12'h000

// ********************************************************
// Descriptor layout in the fetched 128-bit image
// ********************************************************
`define DTR_D_LIM_LO 15:0
`define DTR_D_BASE_LO 39:16
`define DTR_D_ATTR_LO 47:40
`define DTR_D_LIM_HI 51:48
`define DTR_D_ATTR_HI 55:52
`define DTR_D_BASE_MID 63:56
`define DTR_D_BASE_HI 95:64
`define DTR_D_GRAN 55
`define DTR_PAGE_FILL 12'hfff
`define DTR_LIM_PAD 12'h000

// ********************************************************
// Selector and table arithmetic
// ********************************************************
`define DTR_SEL_INDEX 15:3
`define DTR_IDX_PAD 3'h0
`define DTR_DESC_LAST_LEGACY 17'h00007
`define DTR_DESC_LAST_LONG 17'h0000f
`define DTR_UPPER_ZERO 32'h00000000

`endif

// >>> rtl/dtr_pkg.sv
// Types shared by the system-table locator block.
// Assumes dtr_params.svh is in the include path.
package dtr_pkg;

  // ********************************************************
  // Operations issued by the execution core
  // ********************************************************
  typedef enum logic [2:0] {
    load_global_pointer_op = 3'h0,
    save_global_pointer_op = 3'h1,
    load_local_selector_op = 3'h2,
    save_local_selector_op = 3'h3,
    load_vector_pointer_op = 3'h4,
    save_vector_pointer_op = 3'h5,
    load_task_selector_op = 3'h6,
    save_task_selector_op = 3'h7
  } dtr_op_t;

  // ********************************************************
  // Sequencer states, one-hot
  // ********************************************************
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_LOAD_LOCAL = 5'b00010,
    ST_LOAD_TASK = 5'b00100,
    ST_SW_TASK = 5'b01000,
    ST_SW_LOCAL = 5'b10000
  } dtr_state_t;

  typedef struct packed {
    logic [15:0] sel;
    logic [63:0] base;
    logic [31:0] limit;
    logic [11:0] attr;
  } dtr_seg_t;

  typedef struct packed {
    logic req;
    logic [63:0] addr;
    logic done;
    logic [127:0] data;
  } dtr_fetch_t;

  typedef struct packed {
    dtr_state_t state;
    logic [63:0] gt_base;
    logic [15:0] gt_limit;
    logic [63:0] vt_base;
    logic [15:0] vt_limit;
    logic [15:0] pend_task;
    logic [15:0] pend_local;
    logic ready;
    logic rd_valid;
    logic [63:0] rd_base;
    logic [15:0] rd_limit;
    logic [15:0] rd_sel;
    logic fault;
    logic start;
    logic [63:0] start_addr;
  } dtr_top_t;

endpackage

// >>> rtl/dtr_desc_fetch.sv
// Reads one descriptor image from memory for the locator sequencer.
// Assumes the memory port is on ref_clk and answers with a one-cycle mem_ack.
`timescale 1ns/10ps
module dtr_desc_fetch
  import dtr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic start,
  input wire logic [63:0] start_addr,
  output logic mem_req,
  output logic [63:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [127:0] mem_rdata,
  output logic done,
  output logic [127:0] data
);

  dtr_fetch_t s_q;
  dtr_fetch_t s_d;

  // The request stays up until the memory acknowledges it, so a slow memory only adds wait.
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (start) begin
      s_d.req = 1'b1;
      s_d.addr = start_addr;
    end else if (s_q.req && mem_ack) begin
      s_d.req = 1'b0;
      s_d.done = 1'b1;
      s_d.data = mem_rdata;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign mem_req = s_q.req;
  assign mem_addr = s_q.addr;
  assign done = s_q.done;
  assign data = s_q.data;

endmodule

// >>> rtl/dtr_seg_cache.sv
// Selector plus hidden base, limit and attributes of one selector-bearing locator.
// Assumes the parent only fills it after a successful descriptor fetch.
`timescale 1ns/10ps
`include "dtr_params.svh"
module dtr_seg_cache
  import dtr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic fill,
  input wire logic [15:0] fill_sel,
  input wire logic [63:0] fill_base,
  input wire logic [31:0] fill_limit,
  input wire logic [11:0] fill_attr,
  output logic [15:0] sel,
  output logic [63:0] base,
  output logic [31:0] limit,
  output logic [11:0] attr
);

  dtr_seg_t s_q;
  dtr_seg_t s_d;

  // Old contents are simply overwritten; nothing is written back anywhere.
  always_comb begin
    s_d = s_q;
    if (fill) begin
      s_d.sel = fill_sel;
      s_d.base = fill_base;
      s_d.limit = fill_limit;
      s_d.attr = fill_attr;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s_q.sel <= `DTR_SEL_RST; // RL5
      s_q.base <= `DTR_BASE_RST; // RL4 RL5
      s_q.limit <= `DTR_HID_LIMIT_RST; // RL4 RL5
      s_q.attr <= `DTR_ATTR_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign sel = s_q.sel;
  assign base = s_q.base;
  assign limit = s_q.limit;
  assign attr = s_q.attr;

endmodule

// >>> test/dtr_mem_model.sv
// Behavioural memory behind the descriptor fetch port of the locator block.
// Assumes the bench sets image and ack_delay before each selector load.
`timescale 1ns/10ps
module dtr_mem_model (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic mem_req,
  output logic mem_ack,
  output logic [127:0] mem_rdata,
  input wire logic [127:0] image,
  input wire logic [3:0] ack_delay
);
  // ****
  // Responder
  // ****
  logic [3:0] wait_q;
  // Data toggles outside the ack cycle, so a late sample picks up junk.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mem_ack <= 1'b0;
      mem_rdata <= 128'h0;
      wait_q <= 4'h0;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack) begin
        if (wait_q == ack_delay) begin
          mem_ack <= 1'b1;
          mem_rdata <= image;
          wait_q <= 4'h0;
        end else begin
          wait_q <= wait_q + 4'h1;
        end
      end
    end
  end
endmodule

// >>> test/dtr_top_props.sv
// Concurrent checks on the ports of the system-table locator block.
// Assumes it is bound to dtr_top and sees only its ports.
`timescale 1ns/10ps
module dtr_top_props
  import dtr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic long_mode,
  input wire logic op_valid,
  input wire dtr_op_t op_kind,
  input wire logic [63:0] op_base,
  input wire logic [15:0] op_limit,
  input wire logic [15:0] op_sel,
  input wire logic op_ready,
  input wire logic switch_valid,
  input wire logic rd_valid,
  input wire logic [63:0] rd_base,
  input wire logic [15:0] rd_limit,
  input wire logic [15:0] rd_sel,
  input wire logic fault,
  input wire logic mem_req,
  input wire logic [63:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [63:0] global_base,
  input wire logic [15:0] global_limit,
  input wire logic [63:0] vector_base,
  input wire logic [15:0] vector_limit,
  input wire logic [15:0] local_sel,
  input wire logic [63:0] local_base,
  input wire logic [31:0] local_limit,
  input wire logic [15:0] task_sel,
  input wire logic [63:0] task_base,
  input wire logic [31:0] task_limit
);
  // ****
  // Helpers
  // ****
  logic take;
  logic sel_ld;
  logic in_range;
  logic [63:0] op_base_m;
  assign take = op_ready && op_valid && !switch_valid;
  assign sel_ld = take && (op_kind == load_local_selector_op || op_kind == load_task_selector_op);
  // A long-mode descriptor is sixteen bytes, so its last byte lies fifteen further on.
  assign in_range = ({1'h0, op_sel[15:3], 3'h0} + (long_mode ? 17'h0000f : 17'h00007))
    <= {1'h0, global_limit};
  assign op_base_m = op_base & {{32{long_mode}}, 32'hffffffff};
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // ****
  // Assertions
  // ****
  rst_table_a: assert property ($fell(reset) |->
    global_base == 64'h0 && vector_base == 64'h0 && task_base == 64'h0 && global_limit == 16'hffff
    && vector_limit == 16'hffff && task_limit == 32'h0000ffff)
    else $error("table pointer reset value wrong");
  rst_local_a: assert property ($fell(reset) |->
    local_sel == 16'h0 && local_base == 64'h0 && local_limit == 32'h0000ffff)
    else $error("local locator reset value wrong");
  global_load_a: assert property (take && op_kind == load_global_pointer_op |=>
    global_base == $past(op_base_m) && global_limit == $past(op_limit))
    else $error("global pointer load wrong");
  vector_load_a: assert property (take && op_kind == load_vector_pointer_op |=>
    vector_base == $past(op_base_m) && vector_limit == $past(op_limit))
    else $error("vector pointer load wrong");
  save_global_a: assert property (take && op_kind == save_global_pointer_op |=>
    rd_valid && rd_base == $past(global_base) && rd_limit == $past(global_limit) && rd_sel == 16'h0)
    else $error("global save answer wrong");
  save_sel_a: assert property (take && op_kind == save_local_selector_op |=>
    rd_valid && rd_sel == $past(local_sel) && rd_base == 64'h0 && rd_limit == 16'h0)
    else $error("local save answer wrong");
  save_quiet_a: assert property (take && op_kind[0] |=> $stable(global_base)
    && $stable(vector_base) && $stable(local_sel) && $stable(task_sel))
    else $error("save changed a locator");
  fetch_addr_a: assert property (sel_ld && in_range |-> ##2 mem_req &&
    mem_addr == $past(global_base, 2) + {48'h0, $past(op_sel, 2) & 16'hfff8})
    else $error("fetch address wrong");
  range_fault_a: assert property (sel_ld && !in_range |=> fault && !mem_req)
    else $error("out of range selector not refused");
  req_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
    else $error("fetch request dropped early");
  cover property (take && op_kind == save_local_selector_op);
  cover property (mem_req && mem_ack);
  cover property (switch_valid && op_ready);
  cover property (fault);
endmodule

// >>> test/dtr_top_test.sv
// Self-checking bench for the system-table locator block.
// Assumes dtr_top, its package, the memory model and the checker are compiled first.
`timescale 1ns/10ps
module dtr_top_test;
  import dtr_pkg::*;
  logic ref_clk, reset, long_mode, op_valid, op_ready, switch_valid, rd_valid, fault;
  logic mem_req, mem_ack;
  dtr_op_t op_kind;
  logic [63:0] op_base, rd_base, mem_addr, global_base, vector_base, local_base, task_base, b;
  logic [15:0] op_limit, op_sel, switch_task_sel, switch_local_sel, rd_limit, rd_sel, l;
  logic [15:0] global_limit, vector_limit, local_sel, task_sel;
  logic [31:0] local_limit, task_limit;
  logic [11:0] local_attr, task_attr;
  logic [127:0] mem_rdata, image;
  logic [95:0] vexp;
  logic [95:0] exp_q[$];
  logic [3:0] ack_delay;
  int error_cnt, check_count, fault_seen, seed;

  dtr_top dtr_top_inst (.ref_clk(ref_clk), .reset(reset), .long_mode(long_mode),
    .op_valid(op_valid), .op_kind(op_kind), .op_base(op_base), .op_limit(op_limit),
    .op_sel(op_sel), .op_ready(op_ready), .switch_valid(switch_valid),
    .switch_task_sel(switch_task_sel), .switch_local_sel(switch_local_sel),
    .rd_valid(rd_valid), .rd_base(rd_base), .rd_limit(rd_limit), .rd_sel(rd_sel),
    .fault(fault), .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .global_base(global_base), .global_limit(global_limit),
    .vector_base(vector_base), .vector_limit(vector_limit), .local_sel(local_sel),
    .local_base(local_base), .local_limit(local_limit), .local_attr(local_attr),
    .task_sel(task_sel), .task_base(task_base), .task_limit(task_limit), .task_attr(task_attr));
  dtr_mem_model dtr_mem_model_inst (.ref_clk(ref_clk), .reset(reset), .mem_req(mem_req),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .image(image), .ack_delay(ack_delay));

  // ****
  // Tasks
  // ****
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: state %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_rd(input logic [95:0] got, input logic [95:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: save answer %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    if (error_cnt == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Leaves the request standing; the next call or wait_ready replaces it one cycle on.
  task automatic op(input dtr_op_t k, input logic [63:0] ba, input logic [15:0] li,
                    input logic [15:0] s);
    op_valid = 1'b1;
    op_kind = k;
    op_base = ba;
    op_limit = li;
    op_sel = s;
    @(negedge ref_clk);
  endtask
  task automatic save(input dtr_op_t k, input logic [95:0] e);
    exp_q.push_back(e);
    op(k, 64'h0, 16'h0, 16'h0);
  endtask
  task automatic wait_ready;
    int n;
    op_valid = 1'b0;
    switch_valid = 1'b0;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (op_ready !== 1'b1 && n < 100);
    if (op_ready !== 1'b1) begin
      error_cnt++;
      $display("mismatch at %0t: ready never returned", $time);
      report_and_stop();
    end
  endtask
  function automatic logic [107:0] fill(input logic [127:0] d, input logic lm);
    logic [63:0] fb;
    logic [31:0] fl;
    fb = {lm ? d[95:64] : 32'h0, d[63:56], d[39:16]};
    fl = d[55] ? {d[51:48], d[15:0], 12'hfff} : {12'h0, d[51:48], d[15:0]};
    return {fb, fl, d[55:52], d[47:40]};
  endfunction
  task automatic sel_load(input dtr_op_t k, input logic [15:0] s);
    image = {$random(seed), $random(seed), $random(seed), $random(seed)};
    ack_delay = 4'($random(seed)) & 4'h7;
    op(k, 64'h0, 16'h0, s);
    wait_ready();
    if (k == load_local_selector_op)
      chk({local_sel, local_base, local_limit, local_attr}, {s, fill(image, long_mode)});
    else
      chk({task_sel, task_base, task_limit, task_attr}, {s, fill(image, long_mode)});
    save(dtr_op_t'(k + 3'h1), {80'h0, s});
  endtask

  // ****
  // Clock, watcher and sequence
  // ****
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  always @(negedge ref_clk) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        error_cnt++;
        $display("mismatch at %0t: unexpected save answer", $time);
      end else begin
        chk_rd({rd_base, rd_limit, rd_sel}, exp_q.pop_front());
      end
    end
    if (fault === 1'b1)
      fault_seen++;
  end
  initial begin
    seed = 12677;
    error_cnt = 0;
    check_count = 0;
    fault_seen = 0;
    reset = 1'b1;
    long_mode = 1'b0;
    op_valid = 1'b0;
    op_kind = load_global_pointer_op;
    op_base = 64'h0;
    op_limit = 16'h0;
    op_sel = 16'h0;
    switch_valid = 1'b0;
    switch_task_sel = 16'h0;
    switch_local_sel = 16'h0;
    image = 128'h0;
    ack_delay = 4'h0;
    repeat (16) @(negedge ref_clk);
    reset = 1'b0;
    @(negedge ref_clk);
    chk({global_base, vector_base}, 128'h0);
    chk({local_base, task_base}, 128'h0);
    chk({global_limit, vector_limit, task_limit, local_limit, local_sel, task_sel},
        {32'hffffffff, 64'h0000ffff0000ffff, 32'h0});
    save(save_global_pointer_op, {64'h0, 16'hffff, 16'h0});
    save(save_vector_pointer_op, {64'h0, 16'hffff, 16'h0});
    save(save_local_selector_op, 96'h0);
    save(save_task_selector_op, 96'h0);
    for (int i = 0; i < 6; i++) begin
      long_mode = i[0];
      b = {$random(seed), $random(seed)};
      l = 16'($random(seed));
      op(load_global_pointer_op, b, l, 16'h0);
      save(save_global_pointer_op, {b & {{32{long_mode}}, 32'hffffffff}, l, 16'h0});
      vexp = {~b & {{32{long_mode}}, 32'hffffffff}, ~l, 16'h0};
      op(load_vector_pointer_op, ~b, ~l, 16'h0);
      save(save_vector_pointer_op, vexp);
    end
    op(load_global_pointer_op, b, 16'hffff, 16'h0);
    for (int j = 0; j < 6; j++) begin
      long_mode = j[1];
      sel_load(j[0] ? load_task_selector_op : load_local_selector_op,
               (16'($random(seed)) & 16'h0ff8) | 16'(j));
    end
    long_mode = 1'b0;
    op(load_global_pointer_op, b, 16'h000f, 16'h0);
    sel_load(load_task_selector_op, 16'h0008);
    op(load_task_selector_op, 64'h0, 16'h0, 16'h0010);
    wait_ready();
    repeat (2) @(negedge ref_clk);
    chk({112'h0, task_sel}, {112'h0, 16'h0008});
    chk(128'(fault_seen), 128'h1);
    op(load_global_pointer_op, b, 16'hffff, 16'h0);
    long_mode = 1'b1;
    ack_delay = 4'h2;
    switch_valid = 1'b1;
    switch_task_sel = 16'h0128;
    switch_local_sel = 16'h0230;
    // The vector load offered beside the switch must lose to it.
    op(load_vector_pointer_op, b, l, 16'h0);
    wait_ready();
    chk({task_sel, task_base, task_limit, task_attr}, {16'h0128, fill(image, 1'b1)});
    chk({local_sel, local_base, local_limit, local_attr}, {16'h0230, fill(image, 1'b1)});
    save(save_vector_pointer_op, vexp);
    wait_ready();
    repeat (2) @(negedge ref_clk);
    chk(128'(exp_q.size()), 128'h0);
    report_and_stop();
  end
endmodule

bind dtr_top dtr_top_props dtr_top_props_inst (.ref_clk(ref_clk), .reset(reset),
  .long_mode(long_mode), .op_valid(op_valid), .op_kind(op_kind), .op_base(op_base),
  .op_limit(op_limit), .op_sel(op_sel), .op_ready(op_ready), .switch_valid(switch_valid),
  .rd_valid(rd_valid), .rd_base(rd_base), .rd_limit(rd_limit), .rd_sel(rd_sel),
  .fault(fault), .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
  .global_base(global_base), .global_limit(global_limit), .vector_base(vector_base),
  .vector_limit(vector_limit), .local_sel(local_sel), .local_base(local_base),
  .local_limit(local_limit), .task_sel(task_sel), .task_base(task_base),
  .task_limit(task_limit));
